// ===== irq_pkg.sv
// Purpose: constants for the interrupt enable and idle wakeup block
// Assumes: aclk is the oscillator clock, twelve clocks make one machine cycle
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package irq_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFF_IE = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFF_IDLE_CTRL = 8'h0c;
  localparam logic [7:0] OFF_TIMER_FLAGS = 8'h10;
  localparam logic [7:0] OFF_POLL = 8'h14;
  // enable register fields
  localparam int IE_EXT0 = 0;
  localparam int IE_T0 = 1;
  localparam int IE_EXT1 = 2;
  localparam int IE_T1 = 3;
  localparam int IE_SER = 4;
  localparam int IE_T2 = 5;
  localparam int IE_RSVD = 6;
  localparam int IE_GLOBAL = 7;
  localparam logic [7:0] IE_RESET = 8'h00;
  localparam logic [7:0] IE_WR_MASK = 8'hbf;
  // timer flag register fields
  localparam int FL_T0 = 0;
  localparam int FL_T1 = 1;
  localparam int FL_T2 = 2;
  localparam int FL_T2X = 3;
  // block status fields
  localparam int ST_WAKE = 0;
  localparam int ST_RST_EXIT = 1;
  localparam int IDLE_BIT = 0;
  localparam int RAMBLK_BIT = 1;
  // machine cycle timing
  localparam logic [3:0] MC_LAST = 4'hb;
  localparam logic [3:0] CNT_STATE5_PHASE2 = 4'h9;
  localparam logic [3:0] CNT_STATE2_PHASE2 = 4'h3;
  localparam logic [1:0] GRACE_MC = 2'h2;
  // vector numbers, lowest wins
  localparam logic [2:0] VEC_EXT0 = 3'h0;
  localparam logic [2:0] VEC_T0 = 3'h1;
  localparam logic [2:0] VEC_EXT1 = 3'h2;
  localparam logic [2:0] VEC_T1 = 3'h3;
  localparam logic [2:0] VEC_SER = 3'h4;
  localparam logic [2:0] VEC_T2 = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== irq_enable_idle_wakeup.sv
// Purpose: interrupt enable, request polling and idle wakeup logic
// Assumes: timer events are one-clock pulses on aclk, pins are asynchronous
// Notes: registers sit on an AXI4-Lite slave
// Operation
// - six vectors: two external pins, three timers, serial port
// - an enable bit of one permits its source, zero blocks it
// - global enable bit seven at zero blocks every interrupt
// - enables: timer2 bit5, serial 4, timer1 3, ext1 2, timer0 1, ext0 0
// - bit six of the enable register is reserved, stores nothing
// - timer2 request is overflow flag OR external flag
// - vectoring to timer2 leaves both timer2 flags set
// - timer0/1 flags set at state5 phase2, polled next machine cycle
// - timer2 flag set at state2 phase2, polled same machine cycle
// - timer2 roll-overs in clock-out mode raise no request
// - idle entered by software only; cpu halts, interrupt logic runs
// - idle changes no ram or register contents
// - idle ends on any enabled interrupt or a hardware reset
// - reset exit from idle resumes up to two machine cycles first
// - during that grace ram access is blocked, port access is not
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module irq_enable_idle_wakeup
  import irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [irq_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [irq_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_irq_pin_0_n,
  input wire logic external_irq_pin_1_n,
  input wire logic hw_reset_pin_n,
  input wire logic timer0_overflow_event,
  input wire logic timer1_overflow_event,
  input wire logic timer2_overflow_event,
  input wire logic timer2_external_event,
  input wire logic timer2_clockout_mode,
  input wire logic serial_irq_req,
  input wire logic vector_ack,
  output logic irq_pending,
  output logic [2:0] irq_vector_id,
  output logic cpu_halt,
  output logic ram_access_block,
  output logic core_reset_req,
  output logic irq
);
  import irq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] lane0(input logic [7:0] old_v, input logic [31:0] d,
                                       input logic [3:0] strb);
    lane0 = strb[0] ? d[7:0] : old_v;
  endfunction

  function automatic logic [2:0] pick_vec(input logic [5:0] req);
    pick_vec = VEC_EXT0;
    if (req[VEC_EXT0]) pick_vec = VEC_EXT0;
    else if (req[VEC_T0]) pick_vec = VEC_T0;
    else if (req[VEC_EXT1]) pick_vec = VEC_EXT1;
    else if (req[VEC_T1]) pick_vec = VEC_T1;
    else if (req[VEC_SER]) pick_vec = VEC_SER;
    else if (req[VEC_T2]) pick_vec = VEC_T2;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] ext0_sync_ff, ext1_sync_ff, rst_sync_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext0_sync_ff <= 2'h3;
      ext1_sync_ff <= 2'h3;
      rst_sync_ff <= 2'h3;
    end else begin
      ext0_sync_ff <= {ext0_sync_ff[0], external_irq_pin_0_n};
      ext1_sync_ff <= {ext1_sync_ff[0], external_irq_pin_1_n};
      rst_sync_ff <= {rst_sync_ff[0], hw_reset_pin_n};
    end
  end
  logic ext0_level, ext1_level, hw_rst_level;
  assign ext0_level = ~ext0_sync_ff[1];
  assign ext1_level = ~ext1_sync_ff[1];
  assign hw_rst_level = ~rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle state counter
  logic [3:0] mc_cnt_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) mc_cnt_ff <= 4'h0;
    else if (mc_cnt_ff == MC_LAST) mc_cnt_ff <= 4'h0;
    else mc_cnt_ff <= mc_cnt_ff + 4'h1;
  end
  logic at_state5_phase2, at_state2_phase2;
  assign at_state5_phase2 = (mc_cnt_ff == CNT_STATE5_PHASE2);
  assign at_state2_phase2 = (mc_cnt_ff == CNT_STATE2_PHASE2);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff, rdata_ff;
  logic [3:0] w_strb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic do_write;
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_IE) || (a == OFF_IRQ_STATUS) || (a == OFF_IRQ_MASK) ||
             (a == OFF_IDLE_CTRL) || (a == OFF_TIMER_FLAGS) || (a == OFF_POLL);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  logic wr_ie, wr_status, wr_mask, wr_idle, wr_flags;
  assign wr_ie = do_write && (aw_addr_ff == OFF_IE);
  assign wr_status = do_write && (aw_addr_ff == OFF_IRQ_STATUS) && w_strb_ff[0];
  assign wr_mask = do_write && (aw_addr_ff == OFF_IRQ_MASK);
  assign wr_idle = do_write && (aw_addr_ff == OFF_IDLE_CTRL) && w_strb_ff[0];
  assign wr_flags = do_write && (aw_addr_ff == OFF_TIMER_FLAGS) && w_strb_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // enable register
  logic [7:0] ie_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) ie_ff <= IE_RESET;
    else if (wr_ie) ie_ff <= lane0(ie_ff, w_data_ff, w_strb_ff) & IE_WR_MASK;
  end
  AST_IE6_RESERVED: assert property (@(posedge aclk) disable iff (!aresetn)
    !ie_ff[IE_RSVD]) else $error("reserved enable bit holds a one");

  ////////////////////////////////////////////////////////////////////////////
  // timer flags
  logic t0_pend_ff, t1_pend_ff, t2_pend_ff;
  logic [3:0] flags_ff;
  logic t2_ovf_ok;
  logic ack_t0, ack_t1;
  assign t2_ovf_ok = timer2_overflow_event & ~timer2_clockout_mode;
  assign ack_t0 = vector_ack && irq_pending && (irq_vector_id == VEC_T0);
  assign ack_t1 = vector_ack && irq_pending && (irq_vector_id == VEC_T1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t0_pend_ff <= 1'b0;
      t1_pend_ff <= 1'b0;
      t2_pend_ff <= 1'b0;
    end else begin
      // overflow seen mid-cycle is held until its setting phase
      t0_pend_ff <= at_state5_phase2 ? 1'b0 : (t0_pend_ff | timer0_overflow_event);
      t1_pend_ff <= at_state5_phase2 ? 1'b0 : (t1_pend_ff | timer1_overflow_event);
      t2_pend_ff <= at_state2_phase2 ? 1'b0 : (t2_pend_ff | t2_ovf_ok);
    end
  end

  logic set_t0, set_t1, set_t2;
  assign set_t0 = at_state5_phase2 & (t0_pend_ff | timer0_overflow_event);
  assign set_t1 = at_state5_phase2 & (t1_pend_ff | timer1_overflow_event);
  assign set_t2 = at_state2_phase2 & (t2_pend_ff | t2_ovf_ok);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= 4'h0;
    end else begin
      // set wins over software or vector clear
      flags_ff[FL_T0] <= set_t0 | (flags_ff[FL_T0] & ~ack_t0 & ~(wr_flags & w_data_ff[FL_T0]));
      flags_ff[FL_T1] <= set_t1 | (flags_ff[FL_T1] & ~ack_t1 & ~(wr_flags & w_data_ff[FL_T1]));
      // timer2 flags only cleared by software
      flags_ff[FL_T2] <= set_t2 | (flags_ff[FL_T2] & ~(wr_flags & w_data_ff[FL_T2]));
      flags_ff[FL_T2X] <= timer2_external_event |
                          (flags_ff[FL_T2X] & ~(wr_flags & w_data_ff[FL_T2X]));
    end
  end
  AST_T0_SET_PHASE: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flags_ff[FL_T0]) |-> ($past(mc_cnt_ff) == CNT_STATE5_PHASE2))
    else $error("timer0 flag set outside state5 phase2");
  AST_T2_SET_PHASE: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flags_ff[FL_T2]) |-> ($past(mc_cnt_ff) == CNT_STATE2_PHASE2))
    else $error("timer2 flag set outside state2 phase2");
  AST_T2_CLOCKOUT_QUIET: assert property (@(posedge aclk) disable iff (!aresetn)
    (timer2_clockout_mode && !t2_pend_ff && !flags_ff[FL_T2] && !wr_flags) |=>
    !flags_ff[FL_T2]) else $error("timer2 flag raised in clock-out mode");
  AST_T2_KEPT_ON_VECTOR: assert property (@(posedge aclk) disable iff (!aresetn)
    (vector_ack && irq_vector_id == VEC_T2 && flags_ff[FL_T2] && !wr_flags) |=>
    flags_ff[FL_T2]) else $error("timer2 flag cleared on vectoring");
  AST_T1_SET_PHASE: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flags_ff[FL_T1]) |-> ($past(mc_cnt_ff) == CNT_STATE5_PHASE2))
    else $error("timer1 flag set outside state5 phase2");

  ////////////////////////////////////////////////////////////////////////////
  // request gathering and polling
  logic [5:0] raw_req, poll_ff, en_req;
  always_comb begin
    raw_req = 6'h00;
    raw_req[VEC_EXT0] = ext0_level & ie_ff[IE_EXT0];
    raw_req[VEC_T0] = flags_ff[FL_T0] & ie_ff[IE_T0];
    raw_req[VEC_EXT1] = ext1_level & ie_ff[IE_EXT1];
    raw_req[VEC_T1] = flags_ff[FL_T1] & ie_ff[IE_T1];
    raw_req[VEC_SER] = serial_irq_req & ie_ff[IE_SER];
    raw_req[VEC_T2] = (flags_ff[FL_T2] | flags_ff[FL_T2X]) & ie_ff[IE_T2];
  end
  AST_T2_OR: assert property (@(posedge aclk) disable iff (!aresetn)
    raw_req[VEC_T2] == (ie_ff[IE_T2] && (flags_ff[FL_T2] || flags_ff[FL_T2X])))
    else $error("timer2 request is not the or of its flags");

  // snapshot at state5 phase2: timer0/1 flags set on that edge land next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) poll_ff <= 6'h00;
    else if (at_state5_phase2) poll_ff <= raw_req;
  end
  assign en_req = poll_ff & raw_req & {6{ie_ff[IE_GLOBAL]}};
  assign irq_pending = |en_req;
  assign irq_vector_id = pick_vec(en_req);
  AST_GLOBAL_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
    !ie_ff[IE_GLOBAL] |-> !irq_pending) else $error("request with global enable off");
  AST_SOURCE_BLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
    !ie_ff[IE_EXT1] |-> !(irq_pending && irq_vector_id == VEC_EXT1))
    else $error("external 1 request with its enable off");
  AST_T0_POLL_LATER: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flags_ff[FL_T0]) |-> !poll_ff[VEC_T0])
    else $error("timer0 polled in its own setting cycle");
  AST_T1_POLL_LATER: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(flags_ff[FL_T1]) |-> !poll_ff[VEC_T1])
    else $error("timer1 polled in its own setting cycle");

  ////////////////////////////////////////////////////////////////////////////
  // idle control
  typedef enum logic [1:0] {RUN, IDLE, GRACE, HOLD_RST} pwr_state_t;
  pwr_state_t pwr_ff;
  logic [1:0] grace_mc_ff;
  logic wake_evt, rst_exit_evt;
  assign wake_evt = (pwr_ff == IDLE) && irq_pending && !hw_rst_level;
  assign rst_exit_evt = (pwr_ff == IDLE) && hw_rst_level;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_ff <= RUN;
      grace_mc_ff <= 2'h0;
    end else begin
      case (pwr_ff)
        RUN: begin
          if (hw_rst_level) pwr_ff <= HOLD_RST;
          else if (wr_idle && w_data_ff[IDLE_BIT]) pwr_ff <= IDLE;
        end
        IDLE: begin
          if (rst_exit_evt) begin
            pwr_ff <= GRACE;
            grace_mc_ff <= 2'h0;
          end else if (wake_evt) begin
            pwr_ff <= RUN;
          end
        end
        GRACE: begin
          if (mc_cnt_ff == MC_LAST) grace_mc_ff <= grace_mc_ff + 2'h1;
          if (mc_cnt_ff == MC_LAST && grace_mc_ff == GRACE_MC - 2'h1) pwr_ff <= HOLD_RST;
        end
        HOLD_RST: begin
          if (!hw_rst_level) pwr_ff <= RUN;
        end
        default: pwr_ff <= RUN;
      endcase
    end
  end
  // only the cpu is halted; registers and requests keep running
  assign cpu_halt = (pwr_ff == IDLE);
  assign ram_access_block = (pwr_ff == GRACE);
  assign core_reset_req = (pwr_ff == HOLD_RST);
  AST_WAKE_ON_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_halt && irq_pending && !hw_rst_level) |=> (!cpu_halt && !ram_access_block))
    else $error("enabled interrupt did not end idle");
  AST_GRACE_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ram_access_block) |-> ##[13:24] core_reset_req)
    else $error("reset grace after idle not two machine cycles");
  AST_GRACE_BLOCKS_RAM: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_halt && hw_rst_level) |=> (ram_access_block && !core_reset_req))
    else $error("ram not blocked after reset exit from idle");
  AST_IDLE_BY_SOFTWARE: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(cpu_halt) |-> $past(wr_idle))
    else $error("idle entered without a software write");
  AST_IDLE_KEEPS_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
    (cpu_halt && !wr_ie) |=> $stable(ie_ff))
    else $error("enable register changed during idle");

  ////////////////////////////////////////////////////////////////////////////
  // block interrupt status and mask
  logic [7:0] status_ff, mask_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= 8'h00;
      mask_ff <= 8'h00;
    end else begin
      status_ff[ST_WAKE] <= wake_evt | (status_ff[ST_WAKE] &
                            ~(wr_status & w_data_ff[ST_WAKE]));
      status_ff[ST_RST_EXIT] <= rst_exit_evt | (status_ff[ST_RST_EXIT] &
                                ~(wr_status & w_data_ff[ST_RST_EXIT]));
      if (wr_mask) mask_ff <= lane0(mask_ff, w_data_ff, w_strb_ff);
    end
  end
  assign irq = |(status_ff & mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= mapped({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'b00})
        OFF_IE: rdata_ff <= {24'h0, ie_ff};
        OFF_IRQ_STATUS: rdata_ff <= {24'h0, status_ff};
        OFF_IRQ_MASK: rdata_ff <= {24'h0, mask_ff};
        OFF_IDLE_CTRL: rdata_ff <= {30'h0, ram_access_block, cpu_halt};
        OFF_TIMER_FLAGS: rdata_ff <= {28'h0, flags_ff};
        OFF_POLL: rdata_ff <= {26'h0, poll_ff};
        default: rdata_ff <= 32'h0;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule

// ===== cpu_model.sv
// Purpose: cpu core model that takes interrupt vectors
// Assumes: vector_ack is a one-clock pulse on aclk
// Notes: ack_en lets the bench hold a request still for inspection
`timescale 1ns/10ps
module cpu_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_pending,
  input wire logic [2:0] irq_vector_id,
  input wire logic cpu_halt,
  input wire logic ack_en,
  output logic vector_ack,
  output logic [2:0] taken_vec
);
  logic [2:0] gap_ff;
  // one ack, then a pause of eight clocks, like a real vectoring sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_ack <= 1'b0;
      taken_vec <= 3'h7;
      gap_ff <= 3'h0;
    end else if (vector_ack || gap_ff != 3'h0) begin
      vector_ack <= 1'b0;
      gap_ff <= gap_ff + 3'h1;
    end else if (ack_en && irq_pending && !cpu_halt) begin
      vector_ack <= 1'b1;
      taken_vec <= irq_vector_id;
    end
  end
endmodule

// ===== tb_irq_enable_idle_wakeup.sv
// Purpose: self-checking bench for irq_enable_idle_wakeup
// Assumes: 100 MHz aclk, twelve clocks per machine cycle
// Notes: random enable values from a fixed seed, corners written by hand
`timescale 1ns/10ps
module tb_irq_enable_idle_wakeup;
  import irq_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pin0_n = 1'b1, pin1_n = 1'b1, hw_rst_n = 1'b1, ser_req = 1'b0, ack_en = 1'b0;
  logic t0_ev = 1'b0, t1_ev = 1'b0, t2_ev = 1'b0, t2x_ev = 1'b0, t2_clkout = 1'b0;
  logic vector_ack, irq_pending, cpu_halt, ram_access_block, core_reset_req, irq;
  logic [2:0] irq_vector_id, taken_vec;
  logic [31:0] rd;
  logic [7:0] ie;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  irq_enable_idle_wakeup i_irq_enable_idle_wakeup (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .external_irq_pin_0_n(pin0_n),
    .external_irq_pin_1_n(pin1_n), .hw_reset_pin_n(hw_rst_n),
    .timer0_overflow_event(t0_ev), .timer1_overflow_event(t1_ev),
    .timer2_overflow_event(t2_ev), .timer2_external_event(t2x_ev),
    .timer2_clockout_mode(t2_clkout), .serial_irq_req(ser_req), .vector_ack(vector_ack),
    .irq_pending(irq_pending), .irq_vector_id(irq_vector_id), .cpu_halt(cpu_halt),
    .ram_access_block(ram_access_block), .core_reset_req(core_reset_req), .irq(irq));
  cpu_model i_cpu_model (.aclk(aclk), .aresetn(aresetn), .irq_pending(irq_pending),
    .irq_vector_id(irq_vector_id), .cpu_halt(cpu_halt), .ack_en(ack_en),
    .vector_ack(vector_ack), .taken_vec(taken_vec));
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // x is {pending, vector}; thirty clocks cover sync plus two poll cycles
  task automatic pend(input logic [3:0] x);
    repeat (30) @(posedge aclk);
    chk("irq_pending", {31'h0, x[3]}, {31'h0, irq_pending});
    if (x[3]) chk("irq_vector_id", {29'h0, x[2:0]}, {29'h0, irq_vector_id});
  endtask
  task automatic pulse(input int k);
    @(posedge aclk);
    {t2x_ev, t2_ev, t1_ev, t0_ev} <= 4'(1 << k);
    @(posedge aclk);
    {t2x_ev, t2_ev, t1_ev, t0_ev} <= 4'h0;
  endtask
  function automatic logic [3:0] exp_req(input logic [7:0] en, input logic [5:0] src);
    logic [5:0] r;
    r = src & en[5:0];
    if (!en[7] || r == 6'h0) return 4'h0;
    for (int i = 0; i < 6; i++) if (r[i]) return {1'b1, 3'(i)};
    return 4'h0;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(56));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFF_IE);
    chk("enable reset", 32'h0, rd);
    chk("mapped rresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    axr(OFF_IRQ_MASK);
    chk("mask reset", 32'h0, rd);
    axr(8'h20);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped rdata", 32'h0, rd);
    axw(8'h20, 8'hff);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    $display("test registers done");
    pin0_n <= 1'b0;
    pin1_n <= 1'b0;
    ser_req <= 1'b1;
    axw(OFF_IE, 8'h7f);
    chk("mapped bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    pend(4'h0);
    axw(OFF_IE, 8'hff);
    pend(4'h8);
    axr(OFF_IE);
    chk("enable bit6", 32'hbf, rd);
    for (int k = 0; k < 10; k++) begin
      ie = 8'($urandom) & 8'hbf;
      axw(OFF_IE, ie);
      pin0_n <= 1'($urandom);
      pin1_n <= 1'($urandom);
      ser_req <= 1'($urandom);
      @(posedge aclk);
      pend(exp_req(ie, {1'b0, ser_req, 1'b0, ~pin1_n, 1'b0, ~pin0_n}));
      axr(OFF_IE);
      chk("enable readback", {24'h0, ie}, rd);
    end
    pin0_n <= 1'b1;
    pin1_n <= 1'b1;
    ser_req <= 1'b0;
    $display("test enables done");
    axw(OFF_IE, 8'h8a);
    pulse(1);
    pend(4'hb);
    axr(OFF_POLL);
    chk("poll snapshot", 32'h8, rd);
    axr(OFF_TIMER_FLAGS);
    chk("timer1 flag", 32'h2, rd);
    pulse(0);
    pend(4'h9);
    ack_en <= 1'b1;
    pend(4'h0);
    chk("taken vector", 32'h3, {29'h0, taken_vec});
    ack_en <= 1'b0;
    $display("test timer01 done");
    axw(OFF_IE, 8'ha0);
    t2_clkout <= 1'b1;
    pulse(2);
    pend(4'h0);
    axr(OFF_TIMER_FLAGS);
    chk("clockout flags", 32'h0, rd);
    t2_clkout <= 1'b0;
    pulse(2);
    pend(4'hd);
    ack_en <= 1'b1;
    pend(4'hd);
    ack_en <= 1'b0;
    axr(OFF_TIMER_FLAGS);
    chk("timer2 flag after ack", 32'h4, rd);
    axw(OFF_TIMER_FLAGS, 8'h04);
    pend(4'h0);
    pulse(3);
    pend(4'hd);
    axr(OFF_TIMER_FLAGS);
    chk("timer2 external flag", 32'h8, rd);
    axw(OFF_TIMER_FLAGS, 8'h08);
    pend(4'h0);
    $display("test timer2 done");
    axw(OFF_IRQ_MASK, 8'h01);
    axw(OFF_IE, 8'h01);
    axw(OFF_IDLE_CTRL, 8'h01);
    axr(OFF_IDLE_CTRL);
    chk("idle halt", 32'h1, rd);
    pin0_n <= 1'b0;
    pend(4'h0);
    chk("halt without global", 32'h1, {31'h0, cpu_halt});
    ack_en <= 1'b1;
    axw(OFF_IE, 8'h81);
    pend(4'h8);
    chk("halt after wake", 32'h0, {31'h0, cpu_halt});
    chk("vector after wake", 32'h0, {29'h0, taken_vec});
    axr(OFF_IE);
    chk("enable kept", 32'h81, rd);
    axr(OFF_IRQ_STATUS);
    chk("wake status", 32'h1, rd);
    chk("irq raised", 32'h1, {31'h0, irq});
    axw(OFF_IRQ_MASK, 8'h00);
    @(posedge aclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    axw(OFF_IRQ_MASK, 8'h01);
    axw(OFF_IRQ_STATUS, 8'h01);
    @(posedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    ack_en <= 1'b0;
    pin0_n <= 1'b1;
    $display("test idle wake done");
    axw(OFF_IDLE_CTRL, 8'h01);
    hw_rst_n <= 1'b0;
    n = 0;
    while (core_reset_req !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n++;
      if (n == 6) chk("ram block", 32'h1, {31'h0, ram_access_block});
    end
    chk("grace length", 32'h1, {31'h0, n >= 13 && n <= 28});
    hw_rst_n <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("reset req released", 32'h0, {31'h0, core_reset_req});
    chk("ram block released", 32'h0, {31'h0, ram_access_block});
    chk("halt after reset", 32'h0, {31'h0, cpu_halt});
    $display("test reset exit done");
    tally_and_finish();
  end
endmodule
